// ---- include/tvss_map.svh ----
// Register offsets, field positions, standard codes and timing for the
// TV sound standard select and routing block.
// Assumes a 100 MHz system clock and a classic Wishbone register bus.
`ifndef TVSS_MAP_SVH
`define TVSS_MAP_SVH

`define TVSS_CLK_MHZ 100
// Byte addresses of the registers
`define TVSS_ADR_STDSEL 8'h00
`define TVSS_ADR_CTRL 8'h04
`define TVSS_ADR_STATUS 8'h08
`define TVSS_ADR_SRCSEL 8'h0C
`define TVSS_ADR_CFG 8'h10
// Control register fields
`define TVSS_CTRL_AUTO 0
`define TVSS_CTRL_MUTE 1
`define TVSS_CTRL_MAT_LO 2
`define TVSS_CTRL_MAT_HI 3
// Standard codes
`define TVSS_STD_NONE 8'h00
`define TVSS_STD_AUTODET 8'h01
`define TVSS_STD_KOREA 8'h02
`define TVSS_STD_BG_FM 8'h03
`define TVSS_STD_DK1_FM 8'h04
`define TVSS_STD_DK2_FM 8'h05
`define TVSS_STD_DK3_FM 8'h07
`define TVSS_STD_BG_NIC 8'h08
`define TVSS_STD_L_NIC 8'h09
`define TVSS_STD_I_NIC 8'h0A
`define TVSS_STD_DK_NIC 8'h0B
`define TVSS_STD_DK_NIC_HD 8'h0C
`define TVSS_STD_DK_NIC_HD2 8'h0D
`define TVSS_STD_BTSC 8'h20
`define TVSS_STD_BTSC_SAP 8'h21
`define TVSS_STD_JAPAN 8'h30
`define TVSS_STD_RADIO 8'h40
// Timing: probe dwell, NICAM fallback and recovery
`define TVSS_ALT_MS 500
`define TVSS_FALLBACK_MS 100
`define TVSS_RECOVER_MS 1000

`endif

// ---- include/tvss_pkg.sv ----
// Types shared by the TV sound standard select and routing block.
// Constants live in tvss_map.svh.
package tvss_pkg;

    typedef enum logic [1:0] {
        TVSS_IDLE = 2'b00,
        TVSS_DETECT = 2'b01,
        TVSS_RUN = 2'b11
    } tvss_fsm_t;

    typedef enum logic [1:0] {
        TVSS_MODE_MONO = 2'h0,
        TVSS_MODE_STEREO = 2'h1,
        TVSS_MODE_BILING = 2'h2,
        TVSS_MODE_SAP = 2'h3
    } tvss_mode_t;

    typedef enum logic [1:0] {
        TVSS_DEEM_50US = 2'h0,
        TVSS_DEEM_75US = 2'h1,
        TVSS_DEEM_NICAM = 2'h2,
        TVSS_DEEM_OFF = 2'h3
    } tvss_deem_t;

    // What one side of a source channel carries
    typedef enum logic [3:0] {
        TVSS_SIG_ANA_MONO = 4'h0,
        TVSS_SIG_ANA_L = 4'h1,
        TVSS_SIG_ANA_R = 4'h2,
        TVSS_SIG_ANA_A = 4'h3,
        TVSS_SIG_ANA_B = 4'h4,
        TVSS_SIG_NIC_MONO = 4'h5,
        TVSS_SIG_NIC_L = 4'h6,
        TVSS_SIG_NIC_R = 4'h7,
        TVSS_SIG_NIC_A = 4'h8,
        TVSS_SIG_NIC_B = 4'h9,
        TVSS_SIG_SAP = 4'hA
    } tvss_sig_t;

    // Primary / secondary analog input paths
    typedef enum logic [1:0] {
        TVSS_IN_FM1 = 2'h0,
        TVSS_IN_CAR2 = 2'h1,
        TVSS_IN_MPX = 2'h2,
        TVSS_IN_SAP = 2'h3
    } tvss_in_t;

    typedef struct packed {
        tvss_sig_t left;
        tvss_sig_t right;
    } tvss_route_t;

    // Identification and carrier status from the demodulator DSP
    typedef struct packed {
        logic [1:0] carrierOk;
        tvss_mode_t fmIdent;
        tvss_mode_t nicamMode;
        logic nicamBad;
        logic pilot;
        logic sap;
        logic detValid;
        logic [7:0] detStd;
    } tvss_demod_stat_t;

    // Settings that steer the demodulator DSP
    typedef struct packed {
        logic [7:0] std;
        tvss_deem_t deemph;
        tvss_mode_t dematrix;
        logic [1:0] chMute;
        logic nicamSel;
        logic fmMonoHold;
        tvss_in_t primIn;
        tvss_in_t secIn;
    } tvss_cfg_t;

endpackage

// ---- verilog/tvss_ctrl.sv ----
// Standard select, automatic sound select and source channel routing
// for a multistandard TV sound demodulator, with a classic Wishbone
// register slave. Assumes the demodulator status comes from logic on clk.
//
// Function
// - One standard code write sets every demodulator parameter.
// - Auto-detect finds, adopts and reports the present standard.
// - Standard write enables carrier mute; carrierless channel muted, flagged.
// - Two-carrier FM: demodulate both, identify from second carrier.
// - Dematrix manual or automatic; deemphasis from standard code alone.
// - Auto select sets dematrix from identification, no host writes.
// - Auto select alternates B/G dual-FM and B/G NICAM.
// - Same alternation over D/K dual-FM and D/K NICAM.
// - Alternate only without identification; keep an identified standard.
// - Alternation inaudible; output stays on shared FM mono.
// - Bad NICAM falls back to analog mono, returns, with hysteresis.
// - FM-ident standards give mono, stereo or bilingual in all sources.
// - NICAM C-bits choose mode; source 0 analog mono; unusable gives mono.
// - BTSC and radio: pilot gives stereo; SAP carrier detected.
// - BTSC-SAP outputs SAP when present, else BTSC stereo.
// - Four source channels; each output picks one by its select.
// - Source 0: analog mono, stereo or bilingual A/B; analog mono only for NICAM.
// - Source 1: mono/stereo; bilingual puts A left, B right.
// - Sources 3 and 4 carry language A resp. B on both sides.
// - Primary: mono carrier or sum; secondary: second carrier, difference, SAP.
// - With auto select the host may leave output matrices at stereo.
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/1ns
`include "tvss_map.svh"

module tvss_ctrl #(
    parameter int ALT_CYCLES = `TVSS_ALT_MS * `TVSS_CLK_MHZ * 1000,
    parameter int FALLBACK_CYCLES = `TVSS_FALLBACK_MS * `TVSS_CLK_MHZ * 1000,
    parameter int RECOVER_CYCLES = `TVSS_RECOVER_MS * `TVSS_CLK_MHZ * 1000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire tvss_pkg::tvss_demod_stat_t demodStat,
    output tvss_pkg::tvss_cfg_t demodCfg,
    output tvss_pkg::tvss_route_t [3:0] outRoute
);
    import tvss_pkg::*;

    typedef struct packed {
        tvss_fsm_t fsm;
        logic [7:0] std;
        logic autoSel;
        logic muteEn;
        tvss_mode_t manMatrix;
        logic [3:0][2:0] srcSel;
        logic [31:0] altCnt;
        logic [31:0] nicCnt;
        logic nicamUse;
        logic ack;
        logic [31:0] rdat;
        tvss_cfg_t cfg;
        tvss_route_t [3:0] route;
    } tvss_state_t;

    tvss_state_t state_ff;
    tvss_state_t nxt_state;
    tvss_route_t [4:0] srcChan;
    tvss_mode_t curMode;
    logic nicStd;
    logic bgGroup;
    logic dkGroup;
    logic identFound;

    function automatic logic isNicam(input logic [7:0] c);
        return c == `TVSS_STD_BG_NIC || c == `TVSS_STD_L_NIC ||
            c == `TVSS_STD_I_NIC || c == `TVSS_STD_DK_NIC ||
            c == `TVSS_STD_DK_NIC_HD || c == `TVSS_STD_DK_NIC_HD2;
    endfunction

    // Next member of a mono-compatible ring
    function automatic logic [7:0] nextCompat(input logic [7:0] c);
        case (c)
            `TVSS_STD_BG_FM: nextCompat = `TVSS_STD_BG_NIC;
            `TVSS_STD_BG_NIC: nextCompat = `TVSS_STD_BG_FM;
            `TVSS_STD_DK1_FM: nextCompat = `TVSS_STD_DK2_FM;
            `TVSS_STD_DK2_FM: nextCompat = `TVSS_STD_DK3_FM;
            `TVSS_STD_DK3_FM: nextCompat = `TVSS_STD_DK_NIC;
            `TVSS_STD_DK_NIC: nextCompat = `TVSS_STD_DK1_FM;
            default: nextCompat = c;
        endcase
    endfunction

    function automatic tvss_deem_t deemFor(input logic [7:0] c);
        if (isNicam(c)) begin
            deemFor = TVSS_DEEM_NICAM;
        end else if (c == `TVSS_STD_KOREA || c == `TVSS_STD_BTSC ||
                c == `TVSS_STD_BTSC_SAP || c == `TVSS_STD_JAPAN ||
                c == `TVSS_STD_RADIO) begin
            deemFor = TVSS_DEEM_75US;
        end else if (c == `TVSS_STD_NONE || c == `TVSS_STD_AUTODET) begin
            deemFor = TVSS_DEEM_OFF;
        end else begin
            deemFor = TVSS_DEEM_50US;
        end
    endfunction

    function automatic logic [31:0] laneMask(input logic [3:0] sel);
        return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    function automatic tvss_route_t pair(input tvss_sig_t l,
            input tvss_sig_t r);
        pair.left = l;
        pair.right = r;
    endfunction

    assign nicStd = isNicam(state_ff.std);
    assign bgGroup = state_ff.std == `TVSS_STD_BG_FM ||
        state_ff.std == `TVSS_STD_BG_NIC;
    assign dkGroup = state_ff.std == `TVSS_STD_DK1_FM ||
        state_ff.std == `TVSS_STD_DK2_FM ||
        state_ff.std == `TVSS_STD_DK3_FM || state_ff.std == `TVSS_STD_DK_NIC;

    // Broadcast sound mode of the active standard
    always_comb begin
        curMode = TVSS_MODE_MONO;
        if (nicStd) begin
            if (state_ff.nicamUse) begin
                curMode = demodStat.nicamMode;
            end
        end else if (state_ff.std == `TVSS_STD_BTSC ||
                state_ff.std == `TVSS_STD_RADIO) begin
            if (demodStat.pilot) begin
                curMode = TVSS_MODE_STEREO;
            end
        end else if (state_ff.std == `TVSS_STD_BTSC_SAP) begin
            if (demodStat.sap) begin
                curMode = TVSS_MODE_SAP;
            end else if (demodStat.pilot) begin
                curMode = TVSS_MODE_STEREO;
            end
        end else begin
            curMode = demodStat.fmIdent;
        end
    end

    // NICAM identifies only while decoded
    assign identFound = nicStd ? (state_ff.nicamUse &&
        demodStat.nicamMode != TVSS_MODE_MONO) :
        demodStat.fmIdent != TVSS_MODE_MONO;

    // Source channel contents; index 2 is not a demodulator channel
    always_comb begin
        srcChan = '0;
        case (curMode)
            TVSS_MODE_STEREO: begin
                if (nicStd) begin
                    srcChan[1] = pair(TVSS_SIG_NIC_L, TVSS_SIG_NIC_R);
                end else begin
                    srcChan[1] = pair(TVSS_SIG_ANA_L, TVSS_SIG_ANA_R);
                end
                srcChan[3] = srcChan[1];
                srcChan[4] = srcChan[1];
            end
            TVSS_MODE_BILING: begin
                if (nicStd) begin
                    srcChan[1] = pair(TVSS_SIG_NIC_A, TVSS_SIG_NIC_B);
                    srcChan[3] = pair(TVSS_SIG_NIC_A, TVSS_SIG_NIC_A);
                    srcChan[4] = pair(TVSS_SIG_NIC_B, TVSS_SIG_NIC_B);
                end else begin
                    srcChan[1] = pair(TVSS_SIG_ANA_A, TVSS_SIG_ANA_B);
                    srcChan[3] = pair(TVSS_SIG_ANA_A, TVSS_SIG_ANA_A);
                    srcChan[4] = pair(TVSS_SIG_ANA_B, TVSS_SIG_ANA_B);
                end
            end
            TVSS_MODE_SAP: begin
                srcChan[1] = pair(TVSS_SIG_ANA_MONO, TVSS_SIG_SAP);
                srcChan[3] = pair(TVSS_SIG_ANA_MONO, TVSS_SIG_ANA_MONO);
                srcChan[4] = pair(TVSS_SIG_SAP, TVSS_SIG_SAP);
            end
            default: begin
                if (nicStd && state_ff.nicamUse) begin
                    srcChan[1] = pair(TVSS_SIG_NIC_MONO, TVSS_SIG_NIC_MONO);
                end else begin
                    srcChan[1] = pair(TVSS_SIG_ANA_MONO, TVSS_SIG_ANA_MONO);
                end
                srcChan[3] = srcChan[1];
                srcChan[4] = srcChan[1];
            end
        endcase
        // Source 0 never carries digital sound
        if (nicStd || curMode == TVSS_MODE_SAP) begin
            srcChan[0] = pair(TVSS_SIG_ANA_MONO, TVSS_SIG_ANA_MONO);
        end else if (curMode == TVSS_MODE_BILING) begin
            srcChan[0] = srcChan[1];
        end else begin
            srcChan[0] = srcChan[1];
        end
        srcChan[2] = srcChan[0];
    end

    always_comb begin
        logic [31:0] m;
        logic [31:0] old;
        logic hit;
        nxt_state = state_ff;
        m = laneMask(wb_sel_i) & wb_dat_i;
        old = '0;
        hit = wb_cyc_i && wb_stb_i && !state_ff.ack;
        nxt_state.ack = hit;
        nxt_state.rdat = '0;

        case (state_ff.fsm)
            TVSS_DETECT: begin
                if (demodStat.detValid) begin
                    nxt_state.std = demodStat.detStd;
                    nxt_state.fsm = TVSS_RUN;
                end
            end
            TVSS_RUN: begin
                // Probe compatible standards until identified
                if (state_ff.autoSel && (bgGroup || dkGroup) &&
                        !identFound) begin
                    if (state_ff.altCnt >= 32'(ALT_CYCLES - 1)) begin
                        nxt_state.altCnt = '0;
                        nxt_state.std = nextCompat(state_ff.std);
                    end else begin
                        nxt_state.altCnt = state_ff.altCnt + 32'h1;
                    end
                end else begin
                    nxt_state.altCnt = '0;
                end
            end
            default: nxt_state.altCnt = '0;
        endcase

        // Asymmetric counts give the fallback its hysteresis
        if (!nicStd) begin
            nxt_state.nicamUse = 1'b1;
            nxt_state.nicCnt = '0;
        end else if (state_ff.nicamUse == demodStat.nicamBad) begin
            if (state_ff.nicamUse &&
                    state_ff.nicCnt >= 32'(FALLBACK_CYCLES - 1)) begin
                nxt_state.nicamUse = 1'b0;
                nxt_state.nicCnt = '0;
            end else if (!state_ff.nicamUse &&
                    state_ff.nicCnt >= 32'(RECOVER_CYCLES - 1)) begin
                nxt_state.nicamUse = 1'b1;
                nxt_state.nicCnt = '0;
            end else begin
                nxt_state.nicCnt = state_ff.nicCnt + 32'h1;
            end
        end else begin
            nxt_state.nicCnt = '0;
        end

        if (hit) begin
            case (wb_adr_i)
                `TVSS_ADR_STDSEL: old = {24'h0, state_ff.std};
                `TVSS_ADR_CTRL: old = {28'h0, state_ff.manMatrix,
                    state_ff.muteEn, state_ff.autoSel};
                `TVSS_ADR_STATUS: old = {22'h0, state_ff.fsm,
                    demodStat.sap, demodStat.pilot, state_ff.nicamUse,
                    curMode, state_ff.cfg.chMute, 1'b0};
                `TVSS_ADR_SRCSEL: old = {20'h0, state_ff.srcSel};
                `TVSS_ADR_CFG: old = {20'h0, state_ff.cfg.primIn,
                    state_ff.cfg.secIn, state_ff.cfg.dematrix,
                    state_ff.cfg.deemph, 4'h0};
                default: old = '0;
            endcase
            nxt_state.rdat = old;
            m = m | (old & ~laneMask(wb_sel_i));
            if (wb_we_i) begin
                case (wb_adr_i)
                    `TVSS_ADR_STDSEL: begin
                        nxt_state.std = m[7:0];
                        nxt_state.muteEn = 1'b1;
                        nxt_state.altCnt = '0;
                        nxt_state.nicamUse = 1'b1;
                        nxt_state.nicCnt = '0;
                        nxt_state.fsm = (m[7:0] == `TVSS_STD_AUTODET) ?
                            TVSS_DETECT : TVSS_RUN;
                    end
                    `TVSS_ADR_CTRL: begin
                        nxt_state.autoSel = m[`TVSS_CTRL_AUTO];
                        nxt_state.muteEn = m[`TVSS_CTRL_MUTE];
                        nxt_state.manMatrix = tvss_mode_t'(
                            m[`TVSS_CTRL_MAT_HI:`TVSS_CTRL_MAT_LO]);
                    end
                    `TVSS_ADR_SRCSEL: nxt_state.srcSel = m[11:0];
                    default: ;
                endcase
            end
        end

        // Demodulator settings follow the standard code
        nxt_state.cfg.std = state_ff.std;
        nxt_state.cfg.deemph = deemFor(state_ff.std);
        nxt_state.cfg.dematrix = state_ff.autoSel ? curMode :
            state_ff.manMatrix;
        nxt_state.cfg.chMute = {2{state_ff.muteEn}} &
            ~demodStat.carrierOk;
        nxt_state.cfg.nicamSel = nicStd && state_ff.nicamUse;
        nxt_state.cfg.fmMonoHold = state_ff.autoSel &&
            (bgGroup || dkGroup) && !identFound;
        nxt_state.cfg.primIn = (state_ff.std == `TVSS_STD_BTSC ||
            state_ff.std == `TVSS_STD_BTSC_SAP ||
            state_ff.std == `TVSS_STD_JAPAN ||
            state_ff.std == `TVSS_STD_RADIO) ? TVSS_IN_MPX : TVSS_IN_FM1;
        if (state_ff.std == `TVSS_STD_BTSC_SAP && demodStat.sap) begin
            nxt_state.cfg.secIn = TVSS_IN_SAP;
        end else begin
            nxt_state.cfg.secIn = (nxt_state.cfg.primIn == TVSS_IN_MPX) ?
                TVSS_IN_MPX : TVSS_IN_CAR2;
        end
        // Probing holds every output on analog mono
        for (int i = 0; i < 4; i++) begin
            if (nxt_state.cfg.fmMonoHold) begin
                nxt_state.route[i] = pair(TVSS_SIG_ANA_MONO,
                    TVSS_SIG_ANA_MONO);
            end else if (state_ff.srcSel[i] <= 3'h4) begin
                nxt_state.route[i] = srcChan[state_ff.srcSel[i]];
            end else begin
                nxt_state.route[i] = srcChan[0];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    assign wb_ack_o = state_ff.ack;
    assign wb_dat_o = state_ff.rdat;
    assign demodCfg = state_ff.cfg;
    assign outRoute = state_ff.route;

endmodule

// ---- tb/tvss_ctrl_props.sv ----
// Concurrent checks on the ports of tvss_ctrl: bus handshake and routing.
// Assumes ce is held high by the bench and one clock domain.
`timescale 1ns/1ns
module tvss_ctrl_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire tvss_pkg::tvss_demod_stat_t demodStat,
    input wire tvss_pkg::tvss_cfg_t demodCfg,
    input wire tvss_pkg::tvss_route_t [3:0] outRoute
);
    import tvss_pkg::*;
    logic [1:0] upCnt_ff;
    logic nicRoute;

    // Past values right after reset are reset values, so wait three edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            upCnt_ff <= 2'h0;
        end else if (upCnt_ff != 2'h3) begin
            upCnt_ff <= upCnt_ff + 2'h1;
        end
    end

    always_comb begin
        nicRoute = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (outRoute[i].left >= TVSS_SIG_NIC_MONO ||
                outRoute[i].right >= TVSS_SIG_NIC_MONO) begin
                nicRoute = 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    ack_latency_a: assert property (ce && wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("no ack after request");
    ack_pulse_a: assert property (ce && wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    ack_cause_a: assert property (ce && !(wb_cyc_i && wb_stb_i)
        |=> !wb_ack_o) else $error("ack without request");
    read_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("data outside ack");
    carrier_mute_a: assert property (upCnt_ff == 2'h3 |->
        (demodCfg.chMute & $past(demodStat.carrierOk)) == 2'h0)
        else $error("muted with carrier");
    deemph_std_a: assert property (upCnt_ff == 2'h3 &&
        demodCfg.std == $past(demodCfg.std) |->
        demodCfg.deemph == $past(demodCfg.deemph))
        else $error("deemphasis moved alone");
    mono_hold_a: assert property (demodCfg.fmMonoHold |->
        outRoute == '0) else $error("probe not mono");
    fm_route_a: assert property (demodCfg.std inside {8'h02, 8'h03,
        8'h04, 8'h05, 8'h07, 8'h20, 8'h30, 8'h40} |-> !nicRoute)
        else $error("digital on analog standard");
endmodule

bind tvss_ctrl tvss_ctrl_props u_props (.clk(clk), .rst(rst), .ce(ce),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .demodStat(demodStat),
    .demodCfg(demodCfg), .outRoute(outRoute));

// ---- tb/tvss_front_model.sv ----
// Demodulator front end: reports carriers, identification and detection.
// Assumes the bench sets the broadcast conditions in bcast.
`timescale 1ns/1ns
module tvss_front_model #(
    parameter int DET_DELAY = 5
) (
    input wire logic clk,
    input wire logic rst,
    input wire tvss_pkg::tvss_cfg_t demodCfg,
    input wire tvss_pkg::tvss_demod_stat_t bcast,
    output tvss_pkg::tvss_demod_stat_t demodStat
);
    import tvss_pkg::*;
    int waitCnt;
    logic [7:0] junk;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            demodStat <= '0;
            waitCnt <= 0;
            junk <= 8'h5A;
        end else begin
            demodStat <= bcast;
            junk <= junk + 8'h35;
            // Detected code is meaningless outside its valid pulse
            demodStat.detValid <= 1'b0;
            demodStat.detStd <= junk;
            // Identification rides on the second carrier only
            if (!bcast.carrierOk[1]) begin
                demodStat.fmIdent <= TVSS_MODE_MONO;
            end
            if (demodCfg.std == 8'h01) begin
                waitCnt <= waitCnt + 1;
                if (waitCnt == DET_DELAY) begin
                    demodStat.detValid <= 1'b1;
                    demodStat.detStd <= bcast.detStd;
                end
            end else begin
                waitCnt <= 0;
            end
        end
    end
endmodule

// ---- tb/tvss_ctrl_bench.sv ----
// Self-checking bench for tvss_ctrl with shortened timing parameters.
// Assumes tvss_front_model stands in for the demodulator front end.
`timescale 1ns/1ns
`include "tvss_map.svh"
module tvss_ctrl_bench;
    import tvss_pkg::*;
    logic clk, rst, cyc, stb, we, ack;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] datW, datR, rd, tmp;
    tvss_demod_stat_t bc, stat;
    tvss_cfg_t cfg;
    tvss_route_t [3:0] route;
    int mismatches, cmp_count, cycles, seed, i;
    logic [7:0] altSeq[$];
    logic [11:0] srcMap;

    tvss_ctrl #(.ALT_CYCLES(16), .FALLBACK_CYCLES(4), .RECOVER_CYCLES(8))
    DUT (.clk(clk), .rst(rst), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW),
        .wb_dat_o(datR), .wb_ack_o(ack), .demodStat(stat),
        .demodCfg(cfg), .outRoute(route));
    tvss_front_model #(.DET_DELAY(5)) front (.clk(clk), .rst(rst),
        .demodCfg(cfg), .bcast(bc), .demodStat(stat));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end

    task summarize;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, datW, sel} <= {2'b11, w, a, d, 4'hF};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rd = datR;
        if (n == 50) begin
            chk(32'h0, 32'h1);
        end
        {cyc, stb, we} <= 3'h0;
    endtask

    task rdChk(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask

    task nicChk(input logic e);
        rdChk(`TVSS_ADR_STATUS, 32'h20, {26'h0, e, 5'h0});
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Expected source channel content: 0 mono,1 stereo,2 bilingual,3 SAP
    function automatic tvss_route_t expRoute(int src, int m, bit nic);
        int l, r, o;
        if (src == 2 || src > 4) src = 0;
        if (src == 0 && nic) m = 0;
        o = (nic && src != 0) ? 5 : 0;
        l = (m == 1) ? 1 : (m == 2) ? ((src == 4) ? 4 : 3) :
            (m == 3 && src == 4) ? 10 : 0;
        r = (m == 1) ? 2 : (m == 2) ? ((src == 3) ? 3 : 4) :
            (m == 3 && (src == 1 || src == 4)) ? 10 : 0;
        expRoute.left = tvss_sig_t'(4'(l + o));
        expRoute.right = tvss_sig_t'(4'(r + o));
    endfunction

    task chkRoutes(input int m, input bit nic);
        for (int k = 0; k < 4; k++) begin
            chk({24'h0, route[k]}, expRoute(int'(srcMap[3*k +: 3]), m, nic));
        end
    endtask

    task waitStd;
        int n;
        logic [7:0] old;
        old = cfg.std;
        n = 0;
        while (cfg.std === old && n < 60) begin
            @(posedge clk);
            n++;
        end
    endtask

    initial begin
        seed = 32'h2838;
        mismatches = 0;
        cmp_count = 0;
        cycles = 0;
        rst = 1'b1;
        {cyc, stb, we, adr, sel, datW} = '0;
        bc = '0;
        tick(2);
        rst <= 1'b0;
        rdChk(`TVSS_ADR_STDSEL, 32'hFF, 32'h0);
        rdChk(`TVSS_ADR_CTRL, 32'hF, 32'h0);
        wb(1'b1, 8'h14, $random(seed));
        rdChk(8'h14, 32'hFFFFFFFF, 32'h0);
        wb(1'b0, `TVSS_ADR_CFG, 32'h0);
        tmp = rd;
        chk(tmp, 32'h130);
        wb(1'b1, `TVSS_ADR_CFG, ~tmp);
        rdChk(`TVSS_ADR_CFG, 32'hFFFFFFFF, tmp);
        tmp = $random(seed);
        wb(1'b1, `TVSS_ADR_SRCSEL, tmp);
        rdChk(`TVSS_ADR_SRCSEL, 32'hFFF, tmp & 32'hFFF);
        srcMap = 12'h119;
        wb(1'b1, `TVSS_ADR_SRCSEL, {20'h0, srcMap});
        for (i = 0; i < 4; i++) begin
            wb(1'b1, `TVSS_ADR_CTRL, i << 2);
            tick(3);
            chk(cfg.dematrix, i);
        end
        $display("test registers done");
        bc.carrierOk <= 2'b01;
        bc.nicamBad <= 1'b1;
        wb(1'b1, `TVSS_ADR_STDSEL, `TVSS_STD_BG_FM);
        rdChk(`TVSS_ADR_CTRL, 32'h2, 32'h2);
        rdChk(`TVSS_ADR_STATUS, 32'h6, 32'h4);
        rdChk(`TVSS_ADR_STDSEL, 32'hFF, 32'h03);
        bc.carrierOk <= 2'b11;
        wb(1'b1, `TVSS_ADR_CTRL, 32'h3);
        altSeq = '{8'h08, 8'h03};
        foreach (altSeq[k]) begin
            waitStd();
            chk(cfg.std, altSeq[k]);
            rdChk(`TVSS_ADR_STDSEL, 32'hFF, altSeq[k]);
        end
        wb(1'b1, `TVSS_ADR_STDSEL, `TVSS_STD_DK1_FM);
        tick(3);
        altSeq = '{8'h05, 8'h07, 8'h0B, 8'h04};
        foreach (altSeq[k]) begin
            waitStd();
            chk(cfg.std, altSeq[k]);
        end
        $display("test alternation done");
        bc.fmIdent <= TVSS_MODE_STEREO;
        wb(1'b1, `TVSS_ADR_STDSEL, `TVSS_STD_BG_FM);
        tick(60);
        chk(cfg.std, 8'h03);
        chk(cfg.dematrix, TVSS_MODE_STEREO);
        rdChk(`TVSS_ADR_STATUS, 32'h318, 32'h308);
        chkRoutes(1, 1'b0);
        bc.fmIdent <= TVSS_MODE_BILING;
        tick(3);
        chk(cfg.dematrix, TVSS_MODE_BILING);
        chkRoutes(2, 1'b0);
        $display("test identification done");
        bc.fmIdent <= TVSS_MODE_MONO;
        bc.nicamMode <= TVSS_MODE_STEREO;
        bc.nicamBad <= 1'b0;
        wb(1'b1, `TVSS_ADR_STDSEL, `TVSS_STD_L_NIC);
        tick(14);
        nicChk(1'b1);
        chkRoutes(1, 1'b1);
        bc.nicamBad <= 1'b1;
        tick(2);
        bc.nicamBad <= 1'b0;
        tick(3);
        nicChk(1'b1);
        bc.nicamBad <= 1'b1;
        tick(8);
        nicChk(1'b0);
        chkRoutes(0, 1'b0);
        chk(cfg.nicamSel, 1'b0);
        bc.nicamBad <= 1'b0;
        tick(4);
        nicChk(1'b0);
        tick(8);
        nicChk(1'b1);
        $display("test nicam done");
        bc.pilot <= 1'b1;
        bc.sap <= 1'b1;
        wb(1'b1, `TVSS_ADR_STDSEL, `TVSS_STD_BTSC);
        tick(3);
        rdChk(`TVSS_ADR_STATUS, 32'hD8, 32'hC8);
        chkRoutes(1, 1'b0);
        wb(1'b1, `TVSS_ADR_STDSEL, `TVSS_STD_BTSC_SAP);
        tick(3);
        chkRoutes(3, 1'b0);
        chk(cfg.secIn, TVSS_IN_SAP);
        bc.sap <= 1'b0;
        tick(3);
        chkRoutes(1, 1'b0);
        $display("test btsc done");
        bc.detStd <= `TVSS_STD_I_NIC;
        wb(1'b1, `TVSS_ADR_STDSEL, `TVSS_STD_AUTODET);
        i = 0;
        do begin
            wb(1'b0, `TVSS_ADR_STDSEL, 32'h0);
            i++;
        end while (rd[7:0] !== 8'h0A && i < 20);
        chk(rd & 32'hFF, 32'h0A);
        rdChk(`TVSS_ADR_STATUS, 32'h300, 32'h300);
        $display("test detection done");
        summarize();
    end
endmodule
